// File: verilog/pbs_pkg.sv
`default_nettype none
package pbs_pkg;
    // ----------------------------------------------------------------
    // geometry
    // ----------------------------------------------------------------
    localparam int ADDR_W = 17;
    localparam int WORDS = 131072;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int BURST_LEN = 4;
    localparam int CNT_W = $clog2(BURST_LEN);
    // ----------------------------------------------------------------
    // timing, reset values and lane masks
    // ----------------------------------------------------------------
    localparam int WAKE_CYCLES = 2;
    localparam logic [1:0] WAKE_LOAD = 2'(WAKE_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_RST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;

    typedef enum logic [1:0] {
        PBS_RUN,
        PBS_SLEEP,
        PBS_WAKE
    } pbs_pwr_t;

    // write controls as sampled at one edge
    typedef struct packed {
        logic full_n;
        logic gate_n;
        logic [LANES-1:0] lane_n;
    } pbs_wr_t;
endpackage
`default_nettype wire

// File: verilog/pbs_core.sv
`default_nettype none
module pbs_core (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pbs_pkg::ADDR_W-1:0] addr,
    input wire logic processor_addr_strobe_n,
    input wire logic cache_ctrl_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic full_width_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [pbs_pkg::LANES-1:0] lane_write_strobe_n,
    input wire logic chip_select_primary_n,
    input wire logic chip_select_second,
    input wire logic chip_select_third_n,
    input wire logic output_drive_enable_n,
    input wire logic burst_order_select,
    input wire logic sleep_request,
    input wire logic [pbs_pkg::DATA_W-1:0] dq_in,
    output logic [pbs_pkg::DATA_W-1:0] dq_out,
    output logic dq_oe
);
    // ----------------------------------------------------------------
    // storage and state
    // ----------------------------------------------------------------
    logic [pbs_pkg::DATA_W-1:0] mem [pbs_pkg::WORDS];
    logic [pbs_pkg::ADDR_W-1:0] base_q;
    logic [pbs_pkg::CNT_W-1:0] cnt_q;
    logic active_q;
    logic drive_q;
    logic [pbs_pkg::DATA_W-1:0] dout_q;
    pbs_pkg::pbs_pwr_t pwr_q;
    logic [1:0] wake_q;
    logic [2:0] sleep_sync_q;
    logic sleep_lvl_q;

    logic run;
    logic selected;
    logic start_p;
    logic start_c;
    logic start;
    pbs_pkg::pbs_wr_t wr;
    logic [pbs_pkg::LANES-1:0] lane_mask;
    logic wr_now;
    logic [pbs_pkg::ADDR_W-1:0] cur_addr;
    logic [pbs_pkg::ADDR_W-1:0] wr_addr;
    logic [pbs_pkg::DATA_W-1:0] old_word;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    function automatic logic [pbs_pkg::LANES-1:0] lanes_of(
        input pbs_pkg::pbs_wr_t w
    );
        logic [pbs_pkg::LANES-1:0] m;
        m = pbs_pkg::LANES_NONE;
        if (!w.full_n) begin
            m = pbs_pkg::LANES_ALL;
        end else if (!w.gate_n) begin
            m = ~w.lane_n;
        end
        return m;
    endfunction

    // order input is a static level, so it is used unsampled
    function automatic logic [pbs_pkg::CNT_W-1:0] low_bits(
        input logic [pbs_pkg::CNT_W-1:0] first,
        input logic [pbs_pkg::CNT_W-1:0] step,
        input logic interleave
    );
        logic [pbs_pkg::CNT_W-1:0] r;
        r = interleave ? (first ^ step) : (first + step);
        return r;
    endfunction

    assign run = (pwr_q == pbs_pkg::PBS_RUN);
    assign selected = !chip_select_primary_n && chip_select_second
        && !chip_select_third_n;
    // processor strobe is dead while the primary select is high
    assign start_p = !processor_addr_strobe_n
        && !chip_select_primary_n;
    assign start_c = !cache_ctrl_addr_strobe_n && !start_p;
    assign start = start_p || start_c;
    assign wr = '{full_n: full_width_write_n, gate_n: byte_write_gate_n,
        lane_n: lane_write_strobe_n};
    assign lane_mask = lanes_of(wr);
    assign cur_addr = {base_q[pbs_pkg::ADDR_W-1:pbs_pkg::CNT_W],
        low_bits(base_q[pbs_pkg::CNT_W-1:0], cnt_q,
        burst_order_select)};
    // lane strobes are ignored on a processor-strobe start edge
    assign wr_now = run && (lane_mask != pbs_pkg::LANES_NONE)
        && ((start_c && selected) || (!start && active_q));
    assign wr_addr = start_c ? addr : cur_addr;
    assign old_word = mem[wr_addr];

    // ----------------------------------------------------------------
    // sleep input synchroniser and power state
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_sync_q <= 3'h0;
        end else begin
            sleep_sync_q <= {sleep_sync_q[1:0], sleep_request};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sleep_lvl_q <= 1'h0;
        end else if (sleep_sync_q[1] == sleep_sync_q[2]) begin
            sleep_lvl_q <= sleep_sync_q[2];
        end
    end

    // burst registers and array keep their contents across sleep
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_q <= pbs_pkg::PBS_RUN;
            wake_q <= 2'h0;
        end else begin
            case (pwr_q)
                pbs_pkg::PBS_RUN: begin
                    if (sleep_lvl_q) begin
                        pwr_q <= pbs_pkg::PBS_SLEEP;
                    end
                end
                pbs_pkg::PBS_SLEEP: begin
                    if (!sleep_lvl_q) begin
                        pwr_q <= pbs_pkg::PBS_WAKE;
                        wake_q <= pbs_pkg::WAKE_LOAD;
                    end
                end
                pbs_pkg::PBS_WAKE: begin
                    if (sleep_lvl_q) begin
                        pwr_q <= pbs_pkg::PBS_SLEEP;
                    end else if (wake_q == 2'h0) begin
                        pwr_q <= pbs_pkg::PBS_RUN;
                    end else begin
                        wake_q <= wake_q - 2'h1;
                    end
                end
                default: begin
                    pwr_q <= pbs_pkg::PBS_RUN;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // address register and burst counter
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            base_q <= pbs_pkg::ADDR_RST;
            cnt_q <= pbs_pkg::CNT_RST;
            active_q <= 1'h0;
        end else if (run) begin
            if (start) begin
                base_q <= addr;
                cnt_q <= pbs_pkg::CNT_RST;
                active_q <= selected;
            end else if (active_q && !burst_advance_n) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // array write and pipelined read
    // ----------------------------------------------------------------
    // write lands on the sampling edge itself, no pulse shaping needed
    always_ff @(posedge clk) begin
        if (wr_now) begin
            for (int k = 0; k < pbs_pkg::LANES; k++) begin
                if (lane_mask[k]) begin
                    mem[wr_addr][k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W]
                        <= dq_in[k*pbs_pkg::LANE_W +: pbs_pkg::LANE_W];
                end
            end
        end
    end

    // second pipeline stage: address register to data-out register
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dout_q <= pbs_pkg::DATA_RST;
        end else if (run) begin
            dout_q <= mem[cur_addr];
        end
    end

    // one edge after selection the array reads and drive turns on at that same edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_q <= 1'h0;
        end else if (!run) begin
            drive_q <= 1'h0;
        end else if (start) begin
            drive_q <= 1'h0;
        end else begin
            drive_q <= active_q && !wr_now;
        end
    end

    assign dq_out = dout_q;
    // output enable is gated without a clock edge
    assign dq_oe = drive_q && !output_drive_enable_n;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_drive_on;
        (run && start_p && selected) ##1 (run && !start && !wr_now)
            |=> drive_q;
    endproperty
    a_drive_on: assert property (p_drive_on)
        else $error("outputs not driving two cycles after select");

    property p_drive_off;
        (run && start && !selected) |=> !drive_q;
    endproperty
    a_drive_off: assert property (p_drive_off)
        else $error("outputs still driving after deselect");

    property p_sleep_quiet;
        (pwr_q != pbs_pkg::PBS_RUN) |=> !drive_q && $stable(base_q);
    endproperty
    a_sleep_quiet: assert property (p_sleep_quiet)
        else $error("activity while powered down");

    property p_wake;
        (pwr_q == pbs_pkg::PBS_SLEEP && !sleep_lvl_q) ##1 !sleep_lvl_q [*2]
            |=> pwr_q == pbs_pkg::PBS_RUN;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake-up not two cycles");

    property p_full_write;
        (wr_now && !full_width_write_n)
            |=> mem[$past(wr_addr)] == $past(dq_in);
    endproperty
    a_full_write: assert property (p_full_write)
        else $error("full-width write did not store all lanes");

    property p_no_gate;
        (full_width_write_n && byte_write_gate_n)
            |=> mem[$past(wr_addr)] === $past(old_word);
    endproperty
    a_no_gate: assert property (p_no_gate)
        else $error("word changed without write gate");

    property p_advance;
        (run && !start && active_q && !burst_advance_n)
            |=> cnt_q == 2'($past(cnt_q) + 2'h1);
    endproperty
    a_advance: assert property (p_advance)
        else $error("burst counter did not advance");

    property p_block;
        (run && chip_select_primary_n && cache_ctrl_addr_strobe_n)
            |=> $stable(base_q);
    endproperty
    a_block: assert property (p_block)
        else $error("processor strobe started while blocked");

    property p_async_oe;
        output_drive_enable_n |-> !dq_oe;
    endproperty
    a_async_oe: assert property (p_async_oe)
        else $error("outputs enabled with drive enable high");
endmodule
`default_nettype wire

// File: verif/pbs_host.sv
`default_nettype none
module pbs_host (
    input wire logic clk,
    output logic [pbs_pkg::ADDR_W-1:0] addr,
    output logic processor_addr_strobe_n,
    output logic cache_ctrl_addr_strobe_n,
    output logic burst_advance_n,
    output logic full_width_write_n,
    output logic byte_write_gate_n,
    output logic [pbs_pkg::LANES-1:0] lane_write_strobe_n,
    output logic chip_select_primary_n,
    output logic chip_select_second,
    output logic chip_select_third_n,
    output logic burst_order_select,
    output logic [pbs_pkg::DATA_W-1:0] dq_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        addr = '0;
        processor_addr_strobe_n = 1'h1;
        cache_ctrl_addr_strobe_n = 1'h1;
        burst_advance_n = 1'h1;
        full_width_write_n = 1'h1;
        byte_write_gate_n = 1'h1;
        lane_write_strobe_n = 4'hF;
        chip_select_primary_n = 1'h0;
        chip_select_second = 1'h1;
        chip_select_third_n = 1'h0;
        burst_order_select = 1'h0;
        dq_in = '0;
    end
    // ------------------------------------------------------------
    // pin cycles
    // ------------------------------------------------------------
    // one clock of pins; every transfer is built from these
    task automatic beat(input logic adv_n, input logic full_n,
            input logic gate_n, input logic [3:0] lanes_n,
            input logic [pbs_pkg::DATA_W-1:0] d);
        burst_advance_n <= adv_n;
        full_width_write_n <= full_n;
        byte_write_gate_n <= gate_n;
        lane_write_strobe_n <= lanes_n;
        dq_in <= d;
        @(posedge clk);
    endtask
    // idle data lines toggle so a stale value cannot pass for data
    task automatic tick(input int n);
        repeat (n) beat(1'h1, 1'h1, 1'h1, 4'hF, ~dq_in);
    endtask
    task automatic burst_advance();
        beat(1'h0, 1'h1, 1'h1, 4'hF, ~dq_in);
    endtask
    // sel is {third select, second select}; 2'h1 selects the part
    task automatic start(input logic cache, input logic prim_n,
            input logic [1:0] sel, input logic [pbs_pkg::ADDR_W-1:0] a);
        addr <= a;
        processor_addr_strobe_n <= cache;
        cache_ctrl_addr_strobe_n <= ~cache;
        chip_select_primary_n <= prim_n;
        chip_select_second <= sel[0];
        chip_select_third_n <= sel[1];
        tick(1);
        addr <= ~a;
        processor_addr_strobe_n <= 1'h1;
        cache_ctrl_addr_strobe_n <= 1'h1;
        chip_select_primary_n <= 1'h0;
        chip_select_second <= 1'h1;
        chip_select_third_n <= 1'h0;
    endtask
    // order only moves while the bus is idle
    task automatic order(input logic v);
        tick(1);
        burst_order_select <= v;
        tick(1);
    endtask
endmodule
`default_nettype wire

// File: verif/tb_pipelined_burst_sram_core.sv
`default_nettype none
module tb_pipelined_burst_sram_core;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [16:0] A = 17'h00012;
    localparam logic [16:0] B = 17'h1F000;
    localparam logic [35:0] LMIX = {9'h1FF, 9'h000, 9'h1FF, 9'h000};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic output_drive_enable_n = 1'h0;
    logic sleep_request = 1'h0;
    logic [35:0] d [4] = '{36'h123456789, 36'hFEDCBA987,
        36'h0F0F0F0F0, 36'hA5A5A5A5A};
    int fails = 0;
    int comparisons = 0;
    wire logic [pbs_pkg::ADDR_W-1:0] addr;
    wire logic processor_addr_strobe_n, cache_ctrl_addr_strobe_n;
    wire logic burst_advance_n, full_width_write_n, byte_write_gate_n;
    wire logic [pbs_pkg::LANES-1:0] lane_write_strobe_n;
    wire logic chip_select_primary_n, chip_select_second, chip_select_third_n;
    wire logic burst_order_select, dq_oe;
    wire logic [pbs_pkg::DATA_W-1:0] dq_in, dq_out;
    pbs_host i_host (.clk, .addr, .processor_addr_strobe_n,
        .cache_ctrl_addr_strobe_n, .burst_advance_n, .full_width_write_n,
        .byte_write_gate_n, .lane_write_strobe_n, .chip_select_primary_n,
        .chip_select_second, .chip_select_third_n, .burst_order_select,
        .dq_in);
    pbs_core i_dut (.clk, .rst_n, .addr, .processor_addr_strobe_n,
        .cache_ctrl_addr_strobe_n, .burst_advance_n, .full_width_write_n,
        .byte_write_gate_n, .lane_write_strobe_n, .chip_select_primary_n,
        .chip_select_second, .chip_select_third_n,
        .output_drive_enable_n, .burst_order_select, .sleep_request,
        .dq_in, .dq_out, .dq_oe);
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic ok, input string m);
        comparisons++;
        if (ok !== 1'h1) begin
            fails++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic results();
        $display("fails=%0d comparisons=%0d", fails, comparisons);
        if (fails == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // burst read; word k sits at low address 2+k, a single read uses e
    task automatic rd(input logic [16:0] a, input int n,
            input logic [35:0] e);
        logic [1:0] p;
        i_host.start(1'h0, 1'h0, 2'h1, a);
        for (int k = 0; k < n; k++) begin
            p = burst_order_select ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
            i_host.burst_advance();
            #1;
            chk(dq_out === (n == 1 ? e : d[p - 2'h2]), "data");
            if (k == 1) chk(dq_oe === 1'h1, "drive late");
        end
    endtask
    task automatic s_burst();
        i_host.start(1'h1, 1'h0, 2'h1, A);
        for (int k = 0; k < 4; k++) begin
            i_host.beat(1'h0, 1'h0, 1'h1, 4'hF, d[k]);
        end
        rd(A, 4, '0);
        i_host.order(1'h1);
        rd(A | 17'h1, 4, '0);
        i_host.order(1'h0);
    endtask
    task automatic s_lanes();
        i_host.start(1'h1, 1'h0, 2'h1, B);
        i_host.beat(1'h1, 1'h0, 1'h1, 4'hF, '1);
        i_host.beat(1'h1, 1'h1, 1'h0, 4'hA, '0);
        i_host.beat(1'h1, 1'h1, 1'h1, 4'h0, '0);
        rd(B, 1, LMIX);
    endtask
    task automatic s_select();
        i_host.start(1'h0, 1'h0, 2'h1, A);
        i_host.burst_advance();
        i_host.burst_advance();
        #1;
        output_drive_enable_n = 1'h1;
        #1 chk(dq_oe === 1'h0, "async off");
        output_drive_enable_n = 1'h0;
        #1 chk(dq_oe === 1'h1, "async on");
        i_host.start(1'h0, 1'h1, 2'h1, B);
        #1 chk(dq_out === d[2] && dq_oe === 1'h1, "blocked");
        i_host.start(1'h1, 1'h0, 2'h0, A);
        #1 chk(dq_oe === 1'h0, "release");
        // reselect, then deselect through the third enable alone
        i_host.start(1'h0, 1'h0, 2'h1, A);
        i_host.burst_advance();
        i_host.burst_advance();
        #1 chk(dq_oe === 1'h1, "reselect drive");
        i_host.start(1'h1, 1'h0, 2'h3, A);
        #1 chk(dq_oe === 1'h0, "third release");
    endtask
    task automatic s_sleep();
        rd(A, 4, '0);
        sleep_request <= 1'h1;
        i_host.tick(6);
        #1 chk(dq_oe === 1'h0, "sleep drive");
        i_host.start(1'h1, 1'h0, 2'h1, A);
        i_host.beat(1'h0, 1'h0, 1'h1, 4'hF, '0);
        sleep_request <= 1'h0;
        i_host.tick(8);
        rd(A, 4, '0);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        #1 chk(dq_oe === 1'h0 && dq_out === pbs_pkg::DATA_RST, "reset");
        s_burst();
        s_lanes();
        s_select();
        s_sleep();
        results();
    end
    // a hang anywhere ends the run as a mismatch
    initial begin
        #50000;
        fails++;
        results();
    end
endmodule
`default_nettype wire
